// ==== inc/dcf_pkg.sv ====
// Package of constants and carrier types for the single clock fifo core.
package dcf_pkg;

  // ********************************************************************
  // Sizes and timing
  // ********************************************************************
  localparam int DATA_W = 9;
  localparam int ADDR_W = 16;
  localparam int DEPTH = 65536;
  localparam logic [ADDR_W:0] DEPTH_CNT = 17'h10000;
  localparam logic [ADDR_W-1:0] OFFSET_RST = 16'h0007;
  localparam int CLK_NS = 40;
  localparam int RSF_NS = 10;
  localparam int RTR_NS = 90;
  localparam int RSF_RAW = RSF_NS / CLK_NS;
  localparam int RSF_CYC = (RSF_RAW < 1) ? 1 : RSF_RAW;
  localparam int RTR_CYC = (RTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RTR_LOAD = 2'(RTR_CYC);

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_AEMPTY = 2;
  localparam int ST_AFULL = 3;
  localparam int ST_DEPTH = 4;
  localparam int ST_RTR = 5;
  localparam int ST_MODE = 6;
  localparam int ST_COUNT = 8;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic en_n;
    logic [DATA_W-1:0] data;
  } dcf_wr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] full_off;
    logic [ADDR_W-1:0] empty_off;
  } dcf_cfg_t;

endpackage

// ==== rtl/dcf_core.sv ====
// Single clock fifo core with flags, retransmit and APB configuration.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module dcf_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dcf_pkg::dcf_wr_t wr,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic retransmit_strobe,
  input wire logic cascade_in_or_load_n,
  output logic [dcf_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic cascade_out_n
);
  import dcf_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  logic [DATA_W-1:0] mem_q [0:DEPTH-1];
  logic [ADDR_W:0] wr_ptr_q, rd_ptr_q, cnt_q;
  logic [ADDR_W:0] wr_ptr_d, rd_ptr_d, cnt_d;
  logic [DATA_W-1:0] data_out_q;
  logic data_oe_q;
  logic empty_n_q, full_n_q, aempty_n_q, afull_n_q;
  logic mode_done_q, depth_mode_q, rt_prev_q;
  logic strap_q;
  logic [1:0] rtr_cnt_q;
  dcf_cfg_t cfg_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // ********************************************************************
  // Decode
  // ********************************************************************
  wire rtr_busy = (rtr_cnt_q != 2'h0);
  wire wr_go = ~wr.en_n & full_n_q & ~rtr_busy;
  wire rd_go = ~read_enable_n & empty_n_q & ~rtr_busy;
  wire rt_go = retransmit_strobe & ~rt_prev_q & ~depth_mode_q & mode_done_q;
  wire [DATA_W-1:0] rd_word = mem_q[rd_ptr_q[ADDR_W-1:0]];
  wire [ADDR_W:0] empty_lim = {1'b0, cfg_q.empty_off};
  wire [ADDR_W:0] full_lim = DEPTH_CNT - {1'b0, cfg_q.full_off};
  wire acc = psel & penable & ~pready_q;
  wire done = psel & penable & pready_q;
  wire hit_cfg = (paddr == CFG_ADDR);
  wire hit_stat = (paddr == STAT_ADDR);
  wire [31:0] stat_word = {7'h00, cnt_q, 1'b0, mode_done_q, rtr_busy,
                           depth_mode_q, afull_n_q, aempty_n_q, full_n_q,
                           empty_n_q};
  wire [31:0] rd_mux = hit_cfg ? cfg_q : (hit_stat ? stat_word : 32'h0000_0000);

  // Read pointer returns to zero on retransmit; write pointer keeps going.
  assign wr_ptr_d = wr_ptr_q + {16'h0000, wr_go};
  assign rd_ptr_d = rt_go ? 17'h00000 : rd_ptr_q + {16'h0000, rd_go};
  assign cnt_d = wr_ptr_d - rd_ptr_d;

  // ********************************************************************
  // Storage
  // ********************************************************************
  // The array has no reset; a full clear of 64K words would cost a long
  // initialisation and the pointers already make stale words unreachable.
  always_ff @(posedge pclk) begin
    if (wr_go) begin
      mem_q[wr_ptr_q[ADDR_W-1:0]] <= wr.data;
    end
  end

  // ********************************************************************
  // Pointers and flags
  // ********************************************************************
  // All flags reset asynchronously to constants, so they are valid as soon
  // as reset falls and free-running clocks cannot disturb them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 17'h00000;
      rd_ptr_q <= 17'h00000;
      cnt_q <= 17'h00000;
      empty_n_q <= 1'b0;
      full_n_q <= 1'b1;
      aempty_n_q <= 1'b0;
      afull_n_q <= 1'b1;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
      empty_n_q <= (cnt_d != 17'h00000);
      full_n_q <= (cnt_d != DEPTH_CNT);
      aempty_n_q <= (cnt_d > empty_lim);
      afull_n_q <= (cnt_d < full_lim);
    end
  end

  // ********************************************************************
  // Output register and drive
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out_q <= 9'h000;
      data_oe_q <= 1'b0;
    end else begin
      if (rd_go) begin
        data_out_q <= rd_word;
      end
      data_oe_q <= ~output_enable_n & (~depth_mode_q | ~read_enable_n);
    end
  end

  // ********************************************************************
  // Mode capture and retransmit recovery
  // ********************************************************************
  // The strap is sampled on every edge while reset is low, so the level seen
  // just before release is kept and the pin may be tied straight to reset.
  // Limitation: the clock must tick at least once while reset is low.
  always_ff @(posedge pclk) begin
    if (!presetn) begin
      strap_q <= cascade_in_or_load_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_done_q <= 1'b0;
      depth_mode_q <= 1'b0;
      rt_prev_q <= 1'b0;
      rtr_cnt_q <= 2'h0;
    end else begin
      mode_done_q <= 1'b1;
      if (!mode_done_q) begin
        depth_mode_q <= strap_q;
      end
      rt_prev_q <= retransmit_strobe;
      if (rt_go) begin
        rtr_cnt_q <= RTR_LOAD;
      end else if (rtr_busy) begin
        rtr_cnt_q <= rtr_cnt_q - 2'h1;
      end
    end
  end

  // ********************************************************************
  // APB slave
  // ********************************************************************
  // One wait state: data is prepared in the first access cycle and the
  // write commits at the edge that samples pready high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{full_off: OFFSET_RST, empty_off: OFFSET_RST};
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit_cfg & ~hit_stat;
      if (acc) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (done && pwrite && hit_cfg) begin
        cfg_q <= pwdata;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // In depth mode the almost-full pin is taken over by the cascade output,
  // whose token passing lives outside this core, so both rest high there.
  logic afull_pin_q, cascade_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afull_pin_q <= 1'b1;
      cascade_q <= 1'b1;
    end else begin
      afull_pin_q <= afull_n_q | depth_mode_q;
      cascade_q <= 1'b1;
    end
  end

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;
  assign empty_flag_n = empty_n_q;
  assign full_flag_n = full_n_q;
  assign almost_empty_n = aempty_n_q;
  assign almost_full_n = afull_pin_q;
  assign cascade_out_n = cascade_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  write_stores_a: assert property (wr_go |=> wr_ptr_q == 17'($past(wr_ptr_q) + 17'h1))
    else $error("accepted write did not advance the write pointer");
  read_presents_a: assert property (rd_go |=> data_out_q == $past(rd_word))
    else $error("accepted read did not present the stored word");
  full_ignore_a: assert property (!full_n_q && !wr.en_n |=> $stable(wr_ptr_q))
    else $error("write accepted while full");
  empty_hold_a: assert property (!empty_n_q && !read_enable_n |=> $stable(data_out_q))
    else $error("output word changed while empty");
  empty_flag_a: assert property (empty_n_q == (cnt_q != 17'h00000))
    else $error("empty flag disagrees with word count");
  full_flag_a: assert property (full_n_q == (cnt_q != DEPTH_CNT))
    else $error("full flag disagrees with word count");
  almost_empty_a: assert property ($stable(cfg_q) |-> aempty_n_q == (cnt_q > empty_lim))
    else $error("almost empty flag disagrees with offset");
  almost_full_a: assert property ($stable(cfg_q) |-> afull_n_q == (cnt_q < full_lim))
    else $error("almost full flag disagrees with offset");
  retransmit_ptr_a: assert property (rt_go |=> rd_ptr_q == 17'h00000 && $stable(wr_ptr_q))
    else $error("retransmit did not rewind only the read pointer");
  recovery_len_a: assert property (rt_go |=> rtr_busy [*3] ##1 !rtr_busy)
    else $error("retransmit recovery length wrong");
  first_word_a: assert property ($rose(empty_n_q) && !read_enable_n && !rtr_busy
                                 |=> data_out_q == $past(rd_word))
    else $error("first word not readable after empty flag rise");
  reset_data_a: assert property (!mode_done_q |-> data_out_q == 9'h000)
    else $error("data outputs not zero after reset release");

  mode_capture_a: assert property ($rose(mode_done_q) |-> depth_mode_q == $past(strap_q))
    else $error("mode strap not taken from the level held in reset");
  cascade_oe_a: assert property (depth_mode_q && read_enable_n |=> !data_oe_q)
    else $error("cascaded device drove outputs without read enable");
  oe_float_a: assert property (output_enable_n |=> !data_oe_q)
    else $error("outputs driven while output enable high");
  afull_pin_a: assert property (!depth_mode_q |=> afull_pin_q == $past(afull_n_q))
    else $error("almost full pin does not follow its flag");
  recovery_hold_a: assert property (rtr_busy && !wr.en_n |=> $stable(wr_ptr_q))
    else $error("write accepted during retransmit recovery");

  depth_mode_c: cover property ($rose(mode_done_q) && depth_mode_q);
  both_sides_c: cover property (wr_go && rd_go);
  full_reached_c: cover property (!full_n_q);
  retransmit_c: cover property (rt_go);
  cfg_write_c: cover property (done && pwrite && hit_cfg);

endmodule // dcf_core

// ==== tb/dcf_pc_model.sv ====
// Producer and consumer model that feeds and drains the fifo core.
`timescale 1ns/1ps
module dcf_pc_model (
  input wire logic pclk,
  input wire logic presetn,
  output dcf_pkg::dcf_wr_t wr,
  output logic read_enable_n
);
  import dcf_pkg::*;
  initial begin
    wr = '{en_n: 1'b1, data: '0};
    read_enable_n = 1'b1;
  end
  // ********
  // One cycle of producer and consumer activity
  // ********
  task automatic step(input logic do_wr, input logic [DATA_W-1:0] d, input logic do_rd);
    for (int k = 0; k < 8 && presetn !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
    wr.en_n <= ~do_wr;
    // Idle data is inverted so a stale word never passes for a fresh one.
    wr.data <= do_wr ? d : ~wr.data;
    read_enable_n <= ~do_rd;
  endtask
endmodule // dcf_pc_model

// ==== tb/dual_clock_fifo_core_tb.sv ====
// Self-checking testbench for the fifo core.
`timescale 1ns/1ps
module dual_clock_fifo_core_tb;
  import dcf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic output_enable_n = 1'b1;
  logic retransmit_strobe = 1'b0;
  logic cascade_sel = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, read_enable_n, data_oe, cascade_out_n;
  logic empty_flag_n, full_flag_n, almost_empty_n, almost_full_n;
  logic [DATA_W-1:0] data_out;
  dcf_wr_t wr;
  int num_errors = 0;
  int cmp_count = 0;
  initial forever #20 pclk = ~pclk;
  dcf_pc_model dcf_pc_model_inst (.pclk(pclk), .presetn(presetn), .wr(wr),
    .read_enable_n(read_enable_n));
  dcf_core dcf_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr(wr), .read_enable_n(read_enable_n),
    .output_enable_n(output_enable_n), .retransmit_strobe(retransmit_strobe),
    .cascade_in_or_load_n(cascade_sel), .data_out(data_out), .data_oe(data_oe),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n),
    .almost_full_n(almost_full_n), .cascade_out_n(cascade_out_n));
  // ********
  // Shared tasks
  // ********
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    #11;
    chk("reset flags", {empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, cascade_out_n},
      32'h0b);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk("data after reset", data_out, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b0, CFG_ADDR, 32'h0);
    chk("cfg reset", rd, 32'h00070007);
    apb(1'b1, CFG_ADDR, 32'h0005_0003);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk("cfg written", rd, 32'h0005_0003);
    apb(1'b1, CFG_ADDR, 32'h0007_0007);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("count after reset", rd[24:8], 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  task automatic t_stream();
    for (int i = 0; i < 7; i++) dcf_pc_model_inst.step(1'b1, 9'(9'h100 | i), 1'b0);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("ef ae at 7", {empty_flag_n, almost_empty_n}, 32'h2);
    dcf_pc_model_inst.step(1'b1, 9'h107, 1'b0);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b1);
    #1 chk("ae at 8", almost_empty_n, 32'h1);
    for (int i = 0; i < 8; i++) begin
      dcf_pc_model_inst.step(1'b0, 9'h0, i < 7);
      #1 chk("read word", data_out, 9'h100 | i);
    end
    chk("ef after drain", empty_flag_n, 32'h0);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b1);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("read on empty", data_out, 32'h107);
  endtask
  task automatic t_oe();
    @(posedge pclk) output_enable_n <= 1'b0;
    @(posedge pclk) output_enable_n <= 1'b1;
    #1 chk("oe on", data_oe, 32'h1);
    @(posedge pclk);
    #1 chk("oe off", data_oe, 32'h0);
  endtask
  task automatic t_retx();
    @(posedge pclk) retransmit_strobe <= 1'b1;
    repeat (2) @(posedge pclk);
    retransmit_strobe <= 1'b0;
    repeat (5) dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("flags after retx", {empty_flag_n, almost_empty_n}, 32'h3);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b1);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("retx first word", data_out, 32'h100);
  endtask
  task automatic t_fill();
    do_reset();
    for (int i = 0; i < DEPTH; i++) dcf_pc_model_inst.step(1'b1, i[8:0], 1'b0);
    dcf_pc_model_inst.step(1'b1, 9'h1ff, 1'b0);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("full flags", {full_flag_n, almost_full_n}, 32'h0);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("count when full", rd[24:8], 32'h10000);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b1);
    dcf_pc_model_inst.step(1'b0, 9'h0, 1'b0);
    #1 chk("full released", {full_flag_n, data_out}, 32'h200);
  endtask
  task automatic t_depth();
    @(posedge pclk) cascade_sel <= 1'b1;
    do_reset();
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("depth mode", rd[6:4], 32'h5);
    @(posedge pclk) output_enable_n <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk("cascade oe idle", data_oe, 32'h0);
    @(posedge pclk) output_enable_n <= 1'b1;
    cascade_sel <= 1'b0;
  endtask
  initial begin
    do_reset();
    @(posedge pclk);
    t_regs();
    t_stream();
    t_oe();
    t_retx();
    t_fill();
    t_depth();
    final_report();
  end
endmodule // dual_clock_fifo_core_tb
